/* common/ipc_pkg.sv */
// Package for the four-level interrupt priority controller.
// Assumes a single system clock and one synchronous reset.
package ipc_pkg;

	// =========================================================
	// Register addresses and reset values
	localparam logic [7:0] IPC_ADDR_ENABLE = 8'ha8;
	localparam logic [7:0] IPC_ADDR_PRIO_LOW = 8'ha9;
	localparam logic [7:0] IPC_ADDR_PRIO_HIGH = 8'haa;
	localparam logic [7:0] IPC_ADDR_STATUS = 8'hab;
	localparam logic [7:0] IPC_ENABLE_RESET = 8'h00;
	localparam logic [6:0] IPC_PRIO_RESET = 7'h00;

	// =========================================================
	// Field positions
	localparam int IPC_NUM_SRC = 7;
	localparam int IPC_NUM_LVL = 4;
	localparam int IPC_BIT_GLOBAL = 7;
	localparam int IPC_SRC_EXT0 = 0;
	localparam int IPC_SRC_TMR0 = 1;
	localparam int IPC_SRC_EXT1 = 2;
	localparam int IPC_SRC_TMR1 = 3;
	localparam int IPC_SRC_SERIAL = 4;
	localparam int IPC_SRC_SYNC = 5;
	localparam int IPC_SRC_ADC = 6;
	localparam int IPC_NUM_SYNC = 6;

endpackage

/* rtl/ipc_level_pick.sv */
// Picks the highest level among the enabled requests, ties going to the
// lowest source index. Purely combinational; the caller registers it.
`timescale 1ns/10ps
module ipc_level_pick #(
	parameter int NUM_SRC = 7
) (
	// Request and level inputs
	input wire logic [NUM_SRC-1:0] req_in,
	input wire logic [NUM_SRC-1:0] lvl_low_in,
	input wire logic [NUM_SRC-1:0] lvl_high_in,
	// Winner
	output logic found_out,
	output logic [2:0] idx_out,
	output logic [1:0] lvl_out
);

	// =========================================================
	// Scan from the last source down so the lowest index wins ties
	always_comb
	begin
		found_out = 1'b0;
		idx_out = 3'h0;
		lvl_out = 2'h0;
		for (int i = NUM_SRC - 1; i >= 0; i--)
		begin
			if (req_in[i] && (!found_out ||
				{lvl_high_in[i], lvl_low_in[i]} >= lvl_out))
			begin
				found_out = 1'b1;
				idx_out = 3'(i);
				lvl_out = {lvl_high_in[i], lvl_low_in[i]};
			end
		end
	end

endmodule // ipc_level_pick

/* rtl/ipc_irq_ctrl.sv */
// Interrupt enable and four-level priority resolution for the core.
// Assumes request flags come in as levels synchronous to clk_sys_in and
// that the core pulses acknowledge and return for one cycle each.
//
// What this block does
// - Enable register at a8, reset zero
// - Timer requests pass only when enabled
// - External requests pass only when enabled
// - Priority registers a9/aa, seven bits used
// - Same bit pair forms two-bit level
// - Bit positions map to the seven sources
// - Higher level preempts active service routine
// - Equal or lower level never preempts
// - Highest pending level served first
// - Fixed polling order breaks equal-level ties
// - Polling order never causes same-level preemption
// - Global enable low masks every source
// - Software flag writes act like hardware
// - Ack sets level flag, return clears it
`timescale 1ns/10ps
module ipc_irq_ctrl
	import ipc_pkg::*;
#(
	parameter int NUM_SRC = ipc_pkg::IPC_NUM_SRC
) (
	// Clock, reset and enable
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic clk_en_in,
	// Register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// Request flags from the sources
	input wire logic ext_irq0_request_in,
	input wire logic timer0_overflow_flag_in,
	input wire logic ext_irq1_request_in,
	input wire logic timer1_overflow_flag_in,
	input wire logic serial_rx_tx_request_in,
	input wire logic [ipc_pkg::IPC_NUM_SYNC-1:0] sync_group_request_in,
	input wire logic adc_done_request_in,
	// Core side
	input wire logic irq_ack_in,
	input wire logic return_from_irq_in,
	output logic irq_req_out,
	output logic [2:0] irq_src_out,
	output logic [1:0] irq_lvl_out
);
	import ipc_pkg::*;

	// =========================================================
	// State
	typedef struct packed {
		logic [7:0] enable;
		logic [6:0] prio_low;
		logic [6:0] prio_high;
		logic [3:0] active;
		logic req;
		logic [2:0] src;
		logic [1:0] lvl;
		logic [7:0] rdata;
	} ipc_state_t;

	ipc_state_t s_q;
	ipc_state_t s_d;

	logic [NUM_SRC-1:0] raw_req;
	logic [NUM_SRC-1:0] gated_req;
	logic pick_found;
	logic [2:0] pick_idx;
	logic [1:0] pick_lvl;
	logic any_active;
	logic [1:0] top_active;
	logic [NUM_SRC-1:0] lvl_ok;

	// =========================================================
	// Source gathering; the sync group shares one slot
	// Flags are sampled as levels, so a software write to a source flag
	// raises or cancels a request exactly like a hardware change.
	always_comb
	begin
		raw_req = '0;
		raw_req[IPC_SRC_EXT0] = ext_irq0_request_in;
		raw_req[IPC_SRC_TMR0] = timer0_overflow_flag_in;
		raw_req[IPC_SRC_EXT1] = ext_irq1_request_in;
		raw_req[IPC_SRC_TMR1] = timer1_overflow_flag_in;
		raw_req[IPC_SRC_SERIAL] = serial_rx_tx_request_in;
		raw_req[IPC_SRC_SYNC] = |sync_group_request_in;
		raw_req[IPC_SRC_ADC] = adc_done_request_in;
	end

	// Per-source masking by its own enable and the global enable
	for (genvar g = 0; g < NUM_SRC; g++)
	begin : g_mask
		assign gated_req[g] = raw_req[g] && s_q.enable[g] &&
			s_q.enable[IPC_BIT_GLOBAL];
		// Checker helper: this source, if pending, must not sit above
		// the level that the picker chose
		assign lvl_ok[g] = !gated_req[g] ||
			{s_q.prio_high[g], s_q.prio_low[g]} <= pick_lvl;
	end

	ipc_level_pick #(
		.NUM_SRC(NUM_SRC)
	) u_pick (
		.req_in(gated_req),
		.lvl_low_in(s_q.prio_low),
		.lvl_high_in(s_q.prio_high),
		.found_out(pick_found),
		.idx_out(pick_idx),
		.lvl_out(pick_lvl)
	);

	// =========================================================
	// Highest active level; a return clears this one, the level being
	// served, so lower routines stay blocked until their own return
	always_comb
	begin
		any_active = |s_q.active;
		top_active = 2'h0;
		for (int l = 0; l < IPC_NUM_LVL; l++)
		begin
			if (s_q.active[l])
			begin
				top_active = 2'(l);
			end
		end
	end

	// =========================================================
	// Next state
	always_comb
	begin
		s_d = s_q;
		// Register writes
		// Unmapped addresses fall through and are dropped
		if (reg_wr_in)
		begin
			case (reg_addr_in)
				IPC_ADDR_ENABLE: s_d.enable = reg_wdata_in;
				IPC_ADDR_PRIO_LOW: s_d.prio_low = reg_wdata_in[6:0];
				IPC_ADDR_PRIO_HIGH: s_d.prio_high = reg_wdata_in[6:0];
				default: ;
			endcase
		end
		// Read data stands in the cycle after the strobe only
		s_d.rdata = 8'h00;
		if (reg_rd_in)
		begin
			case (reg_addr_in)
				IPC_ADDR_ENABLE: s_d.rdata = s_q.enable;
				IPC_ADDR_PRIO_LOW: s_d.rdata = {1'b0, s_q.prio_low};
				IPC_ADDR_PRIO_HIGH: s_d.rdata = {1'b0, s_q.prio_high};
				IPC_ADDR_STATUS: s_d.rdata = {s_q.active, 4'h0};
				default: s_d.rdata = 8'h00;
			endcase
		end
		// Return clears the top level; ack then sets the presented level.
		// Ack after return in the same cycle keeps the new level set.
		if (return_from_irq_in && any_active)
		begin
			s_d.active[top_active] = 1'b0;
		end
		if (irq_ack_in && s_q.req)
		begin
			s_d.active[s_q.lvl] = 1'b1;
		end
		// Present only a winner strictly above every active level
		s_d.req = pick_found &&
			(!any_active || pick_lvl > top_active);
		s_d.src = pick_idx;
		s_d.lvl = pick_lvl;
		// Hold the request down the cycle after an ack so it is not
		// taken twice before the active flag shows.
		if (irq_ack_in)
		begin
			s_d.req = 1'b0;
		end
	end

	// =========================================================
	// State register; reset wins over the clock enable, and a low
	// enable freezes every field, the request outputs included
	always_ff @(posedge clk_sys_in)
	begin
		if (sys_rst_in)
		begin
			s_q.enable <= IPC_ENABLE_RESET;
			s_q.prio_low <= IPC_PRIO_RESET;
			s_q.prio_high <= IPC_PRIO_RESET;
			s_q.active <= 4'h0;
			s_q.req <= 1'b0;
			s_q.src <= 3'h0;
			s_q.lvl <= 2'h0;
			s_q.rdata <= 8'h00;
		end
		else if (clk_en_in)
		begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from the state register
	assign reg_rdata_out = s_q.rdata;
	assign irq_req_out = s_q.req;
	assign irq_src_out = s_q.src;
	assign irq_lvl_out = s_q.lvl;

	// =========================================================
	// Checks
	// Properties watch what this block drives; all share one clock
	global_mask_a: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in)
		clk_en_in && !s_q.enable[IPC_BIT_GLOBAL] |=> !irq_req_out)
		else $error("request shown with global enable low");

	src_mask_a: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in)
		irq_req_out |-> s_q.enable[irq_src_out] ||
			$past(!clk_en_in) || $past(reg_wr_in))
		else $error("request from disabled source");

	no_preempt_a: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in)
		irq_req_out && $stable(s_q.active) && any_active
			&& $past(clk_en_in) |-> irq_lvl_out > top_active)
		else $error("request not above active level");

	preempt_a: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in)
		clk_en_in && pick_found && !irq_ack_in
			&& (!any_active || pick_lvl > top_active)
			|=> irq_req_out)
		else $error("enabled request not presented");

	ack_sets_a: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in)
		clk_en_in && irq_ack_in && irq_req_out && !return_from_irq_in
			|=> s_q.active[$past(irq_lvl_out)])
		else $error("ack did not set level flag");

	ret_clears_a: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in)
		clk_en_in && return_from_irq_in && !irq_ack_in && any_active
			|=> !s_q.active[$past(top_active)])
		else $error("return did not clear level flag");

	tie_order_a: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in)
		clk_en_in && gated_req[0] && gated_req[1]
			&& s_q.prio_low[1:0] == 2'h3 && s_q.prio_high[1:0] == 2'h3
			&& !any_active && !irq_ack_in && !reg_wr_in
			|=> irq_src_out == 3'h0)
		else $error("tie not broken by polling order");

	prio_rd_a: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in)
		reg_rd_in && clk_en_in |=> !reg_rdata_out[7] ||
			$past(reg_addr_in) == IPC_ADDR_ENABLE ||
			$past(reg_addr_in) == IPC_ADDR_STATUS)
		else $error("unused priority bit reads as one");

	// A write to the enable register lands whole at its own edge
	enable_wr_a: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in)
		clk_en_in && reg_wr_in && reg_addr_in == IPC_ADDR_ENABLE
			|=> s_q.enable == $past(reg_wdata_in))
		else $error("enable write not taken");

	// Only the seven used bits of a priority write are kept
	prio_wr_a: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in)
		clk_en_in && reg_wr_in && reg_addr_in == IPC_ADDR_PRIO_LOW
			|=> {1'b0, s_q.prio_low} == ($past(reg_wdata_in) & 8'h7f))
		else $error("priority write not taken");

	// A cleared timer enable keeps that timer off the request line
	tmr_mask_a: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in)
		clk_en_in && !s_q.enable[IPC_SRC_TMR0]
			|=> !irq_req_out || irq_src_out != 3'(IPC_SRC_TMR0))
		else $error("masked timer request shown");

	// Same for an external source whose enable is clear
	ext_mask_a: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in)
		clk_en_in && !s_q.enable[IPC_SRC_EXT1]
			|=> !irq_req_out || irq_src_out != 3'(IPC_SRC_EXT1))
		else $error("masked external request shown");

	// The shown level is the bit pair of the shown source
	lvl_pair_a: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in)
		irq_req_out && $past(clk_en_in) && !$past(reg_wr_in)
			|-> irq_lvl_out == {s_q.prio_high[irq_src_out],
			s_q.prio_low[irq_src_out]})
		else $error("shown level does not match priority bits");

	// The converter input reaches the top slot when set to level 3
	adc_map_a: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in)
		clk_en_in && adc_done_request_in && s_q.enable[IPC_SRC_ADC]
			&& s_q.enable[IPC_BIT_GLOBAL] && s_q.prio_high[IPC_SRC_ADC]
			&& s_q.prio_low[IPC_SRC_ADC] && !s_q.active[3] && !irq_ack_in
			|=> irq_req_out && irq_lvl_out == 2'h3)
		else $error("converter request not shown at level 3");

	// No pending source outranks the level that the picker chose
	top_win_a: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in)
		pick_found |-> &lvl_ok)
		else $error("lower level picked over a pending higher one");

	// A winner that only ties the active level stays hidden
	same_level_a: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in)
		clk_en_in && any_active && pick_lvl == top_active
			|=> !irq_req_out)
		else $error("same-level request shown");

	// The request drops the cycle after an acknowledge
	ack_drop_a: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in)
		clk_en_in && irq_ack_in |=> !irq_req_out)
		else $error("request still shown after ack");

	// A stray return with nothing active changes nothing
	ret_idle_a: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in)
		clk_en_in && return_from_irq_in && !irq_ack_in && !any_active
			|=> s_q.active == 4'h0)
		else $error("return with no level active set a flag");

	// Status reads show the active flags held at the strobe
	status_rd_a: assert property (@(posedge clk_sys_in)
		disable iff (sys_rst_in)
		clk_en_in && reg_rd_in && reg_addr_in == IPC_ADDR_STATUS
			|=> reg_rdata_out == {$past(s_q.active), 4'h0})
		else $error("status read wrong");

endmodule // ipc_irq_ctrl

/* dv/ipc_core_model.sv */
// Behavioural model of the core that takes interrupt calls.
// Assumes the controller's clock and reset; bench commands ack and return.
`timescale 1ns/10ps
module ipc_core_model (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	// Controller side
	input wire logic irq_req_in,
	input wire logic take_in,
	input wire logic ret_cmd_in,
	output logic irq_ack_out = 1'b0,
	output logic return_out = 1'b0
);
	// ==========================================================
	// Pulses
	// Ack waits for a shown request; one cycle so it never repeats
	always @(posedge clk_sys_in)
	begin
		irq_ack_out <= !sys_rst_in && take_in && irq_req_in && !irq_ack_out;
		return_out <= !sys_rst_in && ret_cmd_in;
	end
endmodule // ipc_core_model

/* dv/testbench.sv */
// Self-checking bench for the interrupt priority controller.
// Assumes ipc_pkg and the core model are compiled first.
`timescale 1ns/10ps
module testbench;
	import ipc_pkg::*;
	// ==========================================================
	// Signals
	logic clk_sys_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic take = 1'b0;
	logic ret_cmd = 1'b0;
	logic ce = 1'b1;
	logic [6:0] fl = 7'h00;
	logic [15:0] rn = 16'h000a;
	logic [7:0] en, lo, hi, rdata;
	logic [3:0] act = 4'h0;
	logic ack, ret, req;
	logic [2:0] src;
	logic [1:0] lvl;
	int n_mismatch = 0;
	int checks = 0;

	// ==========================================================
	// Instances; sync flag walks over group bits 5 down to 2 so several members of the group count
	ipc_irq_ctrl uut (
		.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .clk_en_in(ce),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdata),
		.ext_irq0_request_in(fl[0]), .timer0_overflow_flag_in(fl[1]),
		.ext_irq1_request_in(fl[2]), .timer1_overflow_flag_in(fl[3]),
		.serial_rx_tx_request_in(fl[4]),
		.sync_group_request_in({fl[5], 5'h00} >> rn[1:0]),
		.adc_done_request_in(fl[6]), .irq_ack_in(ack),
		.return_from_irq_in(ret), .irq_req_out(req), .irq_src_out(src),
		.irq_lvl_out(lvl));
	ipc_core_model core (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
		.irq_req_in(req), .take_in(take), .ret_cmd_in(ret_cmd),
		.irq_ack_out(ack), .return_out(ret));

	// Clock
	always #2 clk_sys_in = ~clk_sys_in;

	// ==========================================================
	// Helpers
	function automatic logic [15:0] nxt(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	// Expected {shown, level, source}; later hits override earlier ones
	function automatic logic [5:0] ewin();
		logic [5:0] w;
		w = 6'h00;
		for (int l = 0; l < 4; l++)
			for (int s = 6; s >= 0; s--)
				if (fl[s] && en[s] && en[7] && {hi[s], lo[s]} == 2'(l))
					w = {1'b1, 2'(l), 3'(s)};
		if (w[5] && (act >> w[4:3]) != 4'h0)
			w = 6'h00;
		return w;
	endfunction

	task automatic chk(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_in);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rreg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_in);
		rd <= 1'b0;
		#1 chk("register", rdata, e);
	endtask

	task automatic setp(input logic [7:0] e, input logic [7:0] l,
		input logic [7:0] h);
		en = e;
		lo = l;
		hi = h;
		wreg(IPC_ADDR_ENABLE, e);
		wreg(IPC_ADDR_PRIO_LOW, l);
		wreg(IPC_ADDR_PRIO_HIGH, h);
	endtask

	task automatic cwin();
		logic [5:0] w;
		repeat (3) @(posedge clk_sys_in);
		#1 w = ewin();
		chk("winner", {2'b00, req, req ? lvl : 2'b00, req ? src : 3'b000},
			{2'b00, w});
	endtask

	task automatic pulse_ret();
		ret_cmd <= 1'b1;
		@(posedge clk_sys_in);
		ret_cmd <= 1'b0;
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Watchdog so a hang still reaches the verdict
	initial
	begin
		repeat (20000) @(posedge clk_sys_in);
		n_mismatch++;
		complete_run();
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (6) @(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		rreg(IPC_ADDR_ENABLE, 8'h00);
		rreg(IPC_ADDR_PRIO_LOW, 8'h00);
		rreg(IPC_ADDR_PRIO_HIGH, 8'h00);
		rreg(8'h55, 8'h00);
		wreg(IPC_ADDR_PRIO_HIGH, 8'hff);
		rreg(IPC_ADDR_PRIO_HIGH, 8'h7f);
		$display("test registers done");
		// Random masks, levels and flags; no service active
		for (int i = 0; i < 60; i++)
		begin
			rn <= nxt(rn);
			@(posedge clk_sys_in);
			setp({rn[15] | rn[14], rn[6:0]}, {1'b0, rn[13:7]}, {1'b0, rn[12:6]});
			fl <= rn[11:5];
			cwin();
			rreg(IPC_ADDR_ENABLE, en);
		end
		// Corner: two sources tied at the top level, lower index wins
		setp(8'h83, 8'h03, 8'h03);
		fl <= 7'h03;
		cwin();
		$display("test random priority done");
		// Nesting: ext1 at level 1 served, then preemption checks
		setp(8'hff, 8'h45, 8'h40);
		fl <= 7'h04;
		cwin();
		take <= 1'b1;
		act = 4'h2;
		repeat (4) @(posedge clk_sys_in);
		take <= 1'b0;
		rreg(IPC_ADDR_STATUS, 8'h20);
		fl <= 7'h07;
		cwin();
		fl <= 7'h47;
		cwin();
		take <= 1'b1;
		act = 4'ha;
		repeat (4) @(posedge clk_sys_in);
		take <= 1'b0;
		rreg(IPC_ADDR_STATUS, 8'ha0);
		fl <= 7'h07;
		pulse_ret();
		act = 4'h2;
		cwin();
		pulse_ret();
		act = 4'h0;
		cwin();
		pulse_ret();
		cwin();
		$display("test nesting done");
		// Enable low: the write is lost and the request holds
		ce <= 1'b0;
		wreg(IPC_ADDR_ENABLE, 8'h00);
		cwin();
		ce <= 1'b1;
		rreg(IPC_ADDR_ENABLE, 8'hff);
		$display("test clock enable done");
		// Reset in mid-run after an ack clears flags and registers
		take <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		take <= 1'b0;
		sys_rst_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		en = 8'h00;
		act = 4'h0;
		rreg(IPC_ADDR_STATUS, 8'h00);
		rreg(IPC_ADDR_ENABLE, 8'h00);
		cwin();
		$display("test reset done");
		complete_run();
	end
endmodule // testbench
